// ==== hdl/insn_decode_pkg.sv ====
package insn_decode_pkg;

	localparam logic [1:0] fmt_call = 2'h1;
	localparam logic [1:0] fmt_two = 2'h0;
	localparam logic [2:0] sub_illegal = 3'h0;
	localparam logic [2:0] sub_int_branch = 3'h2;
	localparam logic [2:0] sub_upper_const = 3'h4;
	localparam logic [2:0] sub_float_branch = 3'h6;
	localparam logic [2:0] sub_coproc_branch = 3'h7;
	localparam logic [1:0] fmt_mem = 2'h3;
	localparam logic [1:0] fmt_arith = 2'h2;

	// field positions
	localparam int major_hi = 31;
	localparam int dest_lo = 25;
	localparam int sub_hi = 24;
	localparam int sub_lo = 22;
	localparam int op3_lo = 19;
	localparam int rs1_lo = 14;
	localparam int imm_bit = 13;
	localparam int asi_lo = 5;
	localparam int opf_lo = 5;
	localparam int upper_shift = 10;

	// format-three opcodes (arith, major 2)
	localparam logic [5:0] op_tadd = 6'h20;
	localparam logic [5:0] op_tsub = 6'h21;
	localparam logic [5:0] op_tadd_tv = 6'h22;
	localparam logic [5:0] op_tsub_tv = 6'h23;
	localparam logic [5:0] op_sll = 6'h25;
	localparam logic [5:0] op_srl = 6'h26;
	localparam logic [5:0] op_sra = 6'h27;
	localparam logic [5:0] op_fpop1 = 6'h34;
	localparam logic [5:0] op_fpop2 = 6'h35;
	localparam logic [5:0] op_cpop1 = 6'h36;
	localparam logic [5:0] op_cpop2 = 6'h37;
	localparam logic [5:0] op_jump_and_link_reg = 6'h38;
	localparam logic [5:0] op_trap_return = 6'h39;
	localparam logic [5:0] op_ticc = 6'h3a;

	// memory opcode bits: bit2 store, bit4 alternate, bits1:0 size
	localparam int mem_store_bit = 2;
	localparam int mem_alt_bit = 4;
	localparam logic [1:0] size_word = 2'h0;
	localparam logic [1:0] size_byte = 2'h1;
	localparam logic [1:0] size_half = 2'h2;
	localparam logic [1:0] size_dbl = 2'h3;

	// address space tags
	localparam logic [7:0] asi_user_insn = 8'h08;
	localparam logic [7:0] asi_super_insn = 8'h09;
	localparam logic [7:0] asi_user_data = 8'h0a;
	localparam logic [7:0] asi_super_data = 8'h0b;

	localparam int reg_count = 32;

	typedef enum logic [2:0] {
		kind_call, kind_illegal, kind_branch, kind_upper, kind_arith, kind_mem, kind_other
	} insn_kind_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] space;
		logic [3:0] lanes;
		logic write;
		logic dbl_second;
		logic valid;
	} mem_req_t;

	typedef struct packed {
		logic illegal;
		logic misaligned;
		logic privileged;
		logic tag_overflow;
	} trap_flags_t;

endpackage

// ==== hdl/insn_field_decoder.sv ====
// Function
// - classify by two-bit major format field
// - format two subcode selects branch kinds
// - register zero reads zero, writes dropped
// - immediate bit picks register or short immediate
// - two five-bit source selectors
// - destination field is store source otherwise destination
// - upper constant fills high bits, low zero
// - pc-relative target from shifted signed displacement
// - indirect target is rs1 plus operand two
// - memory access carries eight-bit space tag
// - fixed encodings for user/supervisor spaces
// - data tag by mode, alternate from instruction
// - alternate space access needs supervisor mode
// - byte lanes big-endian
// - halfword lane by address bit one
// - doubleword high word at bit two clear
// - misaligned access traps instead of accessing
// - tagged ops flag overflow on nonzero tags
// - shifts never alter condition codes
// - classify delayed and non-delayed transfers
// - delay instruction runs before target
// - nine-bit float/coproc operation field
module insn_field_decoder
	import insn_decode_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// instruction in
	input wire logic insn_valid,
	input wire logic [31:0] insn,
	input wire logic [31:0] pc,
	input wire logic supervisor,
	// register writeback
	input wire logic wb_en,
	input wire logic [4:0] wb_sel,
	input wire logic [31:0] wb_data,
	// decoded fields
	output logic [1:0] major_format_field,
	output logic [2:0] format_two_subcode,
	output logic [5:0] format_three_opcode,
	output logic [4:0] first_source_selector,
	output logic [4:0] second_source_selector,
	output logic [4:0] dest_selector,
	output logic dest_is_store_source,
	output logic [8:0] float_coproc_op,
	output insn_kind_t kind,
	// operands and results
	output logic [31:0] operand_a,
	output logic [31:0] operand_b,
	output logic [31:0] upper_result,
	output logic keeps_cond_codes,
	// control transfer
	output logic [31:0] transfer_target,
	output logic is_transfer,
	output logic is_delayed,
	output logic next_is_delay_slot,
	// memory and traps
	output mem_req_t mem_req,
	output trap_flags_t traps
);

	logic [31:0] regs [reg_count];
	logic [31:0] next_regs [reg_count];

	logic [1:0] next_major;
	logic [2:0] next_sub;
	logic [5:0] next_op3;
	logic [4:0] next_rs1, next_rs2, next_rd;
	logic next_store_src;
	logic [8:0] next_opf;
	insn_kind_t next_kind;
	logic [31:0] next_opa, next_opb, next_upper, next_target;
	logic next_keep_cc, next_xfer, next_delayed, next_slot;
	mem_req_t next_mem;
	trap_flags_t next_traps;

	// register read with the zero register hard-wired
	function automatic logic [31:0] read_reg(input logic [4:0] sel, input logic [31:0] val);
		read_reg = (sel == 5'h00) ? 32'h0000_0000 : val;
	endfunction

	// big-endian lane mask for a given size and low address
	function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] low);
		lane_mask = 4'hf;
		unique case (size)
			size_byte: lane_mask = 4'h8 >> low;
			size_half: lane_mask = low[1] ? 4'h3 : 4'hc;
			size_word: lane_mask = 4'hf;
			size_dbl: lane_mask = 4'hf;
		endcase
	endfunction

	always_comb begin
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] simm;
		logic [31:0] ea;
		logic is_mem, is_store, is_alt, mis;
		logic [1:0] size;
		a = '0;
		b = '0;
		simm = '0;
		ea = '0;
		is_mem = 1'b0;
		is_store = 1'b0;
		is_alt = 1'b0;
		mis = 1'b0;
		size = insn[op3_lo +: 2];
		next_major = insn[major_hi -: 2];
		next_sub = insn[sub_hi:sub_lo];
		next_op3 = insn[op3_lo +: 6];
		next_rs1 = insn[rs1_lo +: 5];
		next_rs2 = insn[4:0];
		next_rd = insn[dest_lo +: 5];
		next_opf = insn[opf_lo +: 9];
		next_kind = kind_other;
		next_upper = {insn[21:0], 10'h000};
		next_keep_cc = 1'b0;
		next_xfer = 1'b0;
		next_delayed = 1'b0;
		next_target = '0;
		next_mem = '0;
		next_traps = '0;
		simm = {{19{insn[12]}}, insn[12:0]};
		a = read_reg(next_rs1, regs[next_rs1]);
		// immediate bit selects operand two
		b = insn[imm_bit] ? simm : read_reg(next_rs2, regs[next_rs2]);
		ea = a + b;
		unique case (next_major)
			fmt_call: begin
				next_kind = kind_call;
				next_xfer = 1'b1;
				next_delayed = 1'b1;
				next_target = pc + {insn[29:0], 2'b00};
			end
			fmt_two: begin
				unique case (next_sub)
					sub_upper_const: begin
						next_kind = kind_upper;
						next_keep_cc = 1'b1;
					end
					sub_int_branch, sub_float_branch, sub_coproc_branch: begin
						next_kind = kind_branch;
						next_xfer = 1'b1;
						next_delayed = 1'b1;
						next_target = pc + {{8{insn[21]}}, insn[21:0], 2'b00};
					end
					default: begin
						// subcode 0 and unassigned codes trap as illegal
						next_kind = kind_illegal;
						next_traps.illegal = 1'b1;
					end
				endcase
			end
			fmt_arith: begin
				next_kind = kind_arith;
				unique case (next_op3)
					op_tadd, op_tsub: next_traps.tag_overflow = |a[1:0] | |b[1:0];
					op_tadd_tv, op_tsub_tv: begin
						next_traps.tag_overflow = |a[1:0] | |b[1:0];
					end
					op_sll, op_srl, op_sra: next_keep_cc = 1'b1;
					op_jump_and_link_reg, op_trap_return: begin
						next_xfer = 1'b1;
						next_delayed = 1'b1;
						next_target = ea;
					end
					op_ticc: begin
						next_xfer = 1'b1;
						next_delayed = 1'b0;
						next_target = ea;
					end
					default: next_kind = kind_arith;
				endcase
				// float ops take their second operand from the register set, not immediate
				if (next_op3 inside {op_fpop1, op_fpop2, op_cpop1, op_cpop2})
					b = read_reg(next_rs2, regs[next_rs2]);
			end
			fmt_mem: begin
				next_kind = kind_mem;
				is_mem = 1'b1;
				is_store = next_op3[mem_store_bit];
				is_alt = next_op3[mem_alt_bit];
				unique case (size)
					size_dbl: mis = |ea[2:0];
					size_word: mis = |ea[1:0];
					size_half: mis = ea[0];
					size_byte: mis = 1'b0;
				endcase
				next_traps.misaligned = mis;
				next_traps.privileged = is_alt & ~supervisor;
				next_mem.addr = ea;
				next_mem.space = is_alt ? insn[asi_lo +: 8] : (supervisor ? asi_super_data : asi_user_data);
				next_mem.lanes = lane_mask(size, ea[1:0]);
				next_mem.write = is_store;
				next_mem.dbl_second = (size == size_dbl) & ea[2];
				next_mem.valid = insn_valid & ~mis & ~next_traps.privileged;
			end
		endcase
		next_store_src = is_mem & is_store;
		next_opa = a;
		next_opb = b;
		// the slot after a delayed transfer always runs before the target
		next_slot = insn_valid & next_delayed;
		if (!insn_valid) begin
			next_traps = '0;
			next_mem.valid = 1'b0;
			next_xfer = 1'b0;
		end
	end

	// writeback into register zero is dropped so reads need no special write path
	always_comb begin
		for (int i = 0; i < reg_count; i++) begin
			next_regs[i] = regs[i];
		end
		if (wb_en && wb_sel != 5'h00)
			next_regs[wb_sel] = wb_data;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < reg_count; i++) begin
				regs[i] <= '0;
			end
			major_format_field <= '0;
			format_two_subcode <= '0;
			format_three_opcode <= '0;
			first_source_selector <= '0;
			second_source_selector <= '0;
			dest_selector <= '0;
			dest_is_store_source <= 1'b0;
			float_coproc_op <= '0;
			kind <= kind_other;
			operand_a <= '0;
			operand_b <= '0;
			upper_result <= '0;
			keeps_cond_codes <= 1'b0;
			transfer_target <= '0;
			is_transfer <= 1'b0;
			is_delayed <= 1'b0;
			next_is_delay_slot <= 1'b0;
			mem_req <= '0;
			traps <= '0;
		end else begin
			regs <= next_regs;
			major_format_field <= next_major;
			format_two_subcode <= next_sub;
			format_three_opcode <= next_op3;
			first_source_selector <= next_rs1;
			second_source_selector <= next_rs2;
			dest_selector <= next_rd;
			dest_is_store_source <= next_store_src;
			float_coproc_op <= next_opf;
			kind <= next_kind;
			operand_a <= next_opa;
			operand_b <= next_opb;
			upper_result <= next_upper;
			keeps_cond_codes <= next_keep_cc;
			transfer_target <= next_target;
			is_transfer <= next_xfer;
			is_delayed <= next_delayed;
			next_is_delay_slot <= next_slot;
			mem_req <= next_mem;
			traps <= next_traps;
		end
	end

endmodule // insn_field_decoder

// ==== testbench/insn_field_decoder_props.sv ====
module insn_field_decoder_props
	import insn_decode_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic insn_valid,
	input wire logic [31:0] insn,
	input wire logic supervisor,
	input wire logic [1:0] major_format_field,
	input wire logic [2:0] format_two_subcode,
	input wire logic dest_is_store_source,
	input wire logic [8:0] float_coproc_op,
	input wire logic [31:0] upper_result,
	input wire logic is_delayed,
	input wire mem_req_t mem_req,
	input wire trap_flags_t traps
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic mem_in = insn_valid && insn[31:30] == fmt_mem;
	property p_major; insn_valid |=> major_format_field == $past(insn[31:30]); endproperty
	a_major: assert property (p_major) else $error("major format wrong");
	property p_sub; insn_valid |=> format_two_subcode == $past(insn[24:22]); endproperty
	a_sub: assert property (p_sub) else $error("subcode wrong");
	property p_upper; insn_valid |=> upper_result == {$past(insn[21:0]), 10'h000}; endproperty
	a_upper: assert property (p_upper) else $error("upper constant wrong");
	property p_fop; insn_valid |=> float_coproc_op == $past(insn[13:5]); endproperty
	a_fop: assert property (p_fop) else $error("operation field wrong");
	property p_store; insn_valid |=> dest_is_store_source == ($past(mem_in) && $past(insn[21])); endproperty
	a_store: assert property (p_store) else $error("store source flag wrong");
	property p_space; mem_in && !insn[23] |=> !mem_req.valid || mem_req.space == ($past(supervisor) ? 8'h0b : 8'h0a); endproperty
	a_space: assert property (p_space) else $error("data space tag wrong");
	property p_priv; mem_in && insn[23] && !supervisor |=> !mem_req.valid && traps.privileged; endproperty
	a_priv: assert property (p_priv) else $error("alternate access in user mode");
	property p_align; mem_req.valid && mem_req.lanes == 4'hf |-> mem_req.addr[1:0] == 2'h0; endproperty
	a_align: assert property (p_align) else $error("misaligned access issued");
	property p_ticc; insn_valid && insn[31:30] == fmt_arith && insn[24:19] == op_ticc |=> !is_delayed; endproperty
	a_ticc: assert property (p_ticc) else $error("trap marked delayed");
endmodule // insn_field_decoder_props
bind insn_field_decoder insn_field_decoder_props props_inst (.core_clk(core_clk), .rst_n(rst_n),
	.insn_valid(insn_valid), .insn(insn), .supervisor(supervisor), .major_format_field(major_format_field),
	.format_two_subcode(format_two_subcode), .dest_is_store_source(dest_is_store_source),
	.float_coproc_op(float_coproc_op), .upper_result(upper_result), .is_delayed(is_delayed),
	.mem_req(mem_req), .traps(traps));

// ==== testbench/mem_model.sv ====
// stand-in for the external memory system: records each access it is offered
module mem_model
	import insn_decode_pkg::*;
(
	// clock
	input wire logic core_clk,
	// request from the decoder
	input wire mem_req_t mem_req,
	// observed
	output logic [7:0] last_space,
	output int n_access
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		n_access = 0;
		last_space = 8'h00;
	end
	always @(posedge core_clk) begin
		if (mem_req.valid === 1'b1) begin
			last_space = mem_req.space;
			n_access = n_access + 1;
		end
	end
endmodule // mem_model

// ==== testbench/tb_risc_instruction_field_decoder.sv ====
module tb_risc_instruction_field_decoder
	import insn_decode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, rst_n = 1'b0, insn_valid = 1'b0, supervisor = 1'b0, wb_en = 1'b0;
	logic [31:0] insn = 32'h0, pc = 32'h0, wb_data = 32'h0;
	logic [4:0] wb_sel = 5'h0;
	logic [1:0] major_format_field;
	logic [2:0] format_two_subcode;
	logic [5:0] format_three_opcode;
	logic [4:0] first_source_selector, second_source_selector, dest_selector;
	logic dest_is_store_source, keeps_cond_codes, is_transfer, is_delayed, next_is_delay_slot;
	logic [8:0] float_coproc_op;
	insn_kind_t kind;
	logic [31:0] operand_a, operand_b, upper_result, transfer_target;
	mem_req_t mem_req;
	trap_flags_t traps;
	logic [7:0] last_space;
	int n_access, n_errors = 0, total_checks = 0, cycles = 0;
	insn_field_decoder insn_field_decoder_inst (.core_clk(core_clk), .rst_n(rst_n), .insn_valid(insn_valid),
		.insn(insn), .pc(pc), .supervisor(supervisor), .wb_en(wb_en), .wb_sel(wb_sel), .wb_data(wb_data),
		.major_format_field(major_format_field), .format_two_subcode(format_two_subcode),
		.format_three_opcode(format_three_opcode), .first_source_selector(first_source_selector),
		.second_source_selector(second_source_selector), .dest_selector(dest_selector),
		.dest_is_store_source(dest_is_store_source), .float_coproc_op(float_coproc_op), .kind(kind),
		.operand_a(operand_a), .operand_b(operand_b), .upper_result(upper_result),
		.keeps_cond_codes(keeps_cond_codes), .transfer_target(transfer_target), .is_transfer(is_transfer),
		.is_delayed(is_delayed), .next_is_delay_slot(next_is_delay_slot), .mem_req(mem_req), .traps(traps));
	mem_model mem_model_inst (.core_clk(core_clk), .mem_req(mem_req), .last_space(last_space), .n_access(n_access));
	always #50 core_clk = ~core_clk;
	task test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// hang guard well above the roughly seventy cycles the sequence needs
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			n_errors = n_errors + 1;
			test_done();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks = total_checks + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [4:0] s, input logic [31:0] d);
		@(posedge core_clk);
		#1 wb_en = 1'b1;
		wb_sel = s;
		wb_data = d;
		@(posedge core_clk);
		#1 wb_en = 1'b0;
	endtask
	// outputs are registered: look just after the edge that samples the instruction
	// valid drops after one sampling edge so each access is offered to memory exactly once
	task run(input logic [31:0] i, input logic s);
		@(posedge core_clk);
		#1 insn = i;
		supervisor = s;
		pc = 32'h1000;
		insn_valid = 1'b1;
		@(posedge core_clk);
		#1 insn_valid = 1'b0;
		#1;
	endtask
	function automatic logic [31:0] f3(logic [1:0] op, logic [5:0] o3, logic [4:0] r1, logic i, logic [12:0] lo);
		return {op, 5'h03, o3, r1, i, lo};
	endfunction
	initial begin
		repeat (12) @(posedge core_clk);
		#1 rst_n = 1'b1;
		wr(5'h01, 32'h100);
		wr(5'h02, 32'h7);
		wr(5'h00, 32'hffff);
		run(f3(2'h3, 6'h00, 5'h01, 1'b1, 13'h0004), 1'b0);
		chk(mem_req.addr, 32'h104);
		chk(mem_req.space, 8'h0a);
		chk(mem_req.lanes, 4'hf);
		run(f3(2'h3, 6'h00, 5'h01, 1'b1, 13'h0004), 1'b1);
		chk(mem_req.space, 8'h0b);
		for (int k = 0; k < 4; k++) begin
			run(f3(2'h3, 6'h01, 5'h01, 1'b1, 13'(k)), 1'b0);
			chk(mem_req.lanes, 4'h8 >> k);
		end
		run(f3(2'h3, 6'h02, 5'h01, 1'b1, 13'h0002), 1'b0);
		chk(mem_req.lanes, 4'h3);
		run(f3(2'h3, 6'h02, 5'h01, 1'b1, 13'h0001), 1'b0);
		chk({traps.misaligned, mem_req.valid}, 2'h2);
		run(f3(2'h3, 6'h03, 5'h01, 1'b1, 13'h0008), 1'b0);
		chk({mem_req.valid, mem_req.dbl_second}, 2'h2);
		run(f3(2'h3, 6'h03, 5'h01, 1'b1, 13'h0004), 1'b0);
		chk(traps.misaligned, 1'b1);
		run(f3(2'h3, 6'h10, 5'h01, 1'b0, 13'h0420), 1'b0);
		chk({traps.privileged, mem_req.valid}, 2'h2);
		run(f3(2'h3, 6'h10, 5'h01, 1'b0, 13'h0420), 1'b1);
		chk(mem_req.space, 8'h21);
		run(f3(2'h3, 6'h04, 5'h01, 1'b1, 13'h0000), 1'b0);
		chk({dest_is_store_source, dest_selector}, 6'h23);
		chk({mem_req.write, mem_req.valid}, 2'h3);
		run(f3(2'h2, 6'h00, 5'h00, 1'b1, 13'h1ffc), 1'b0);
		chk(operand_a, 32'h0);
		chk(operand_b, 32'hfffffffc);
		run(f3(2'h2, 6'h00, 5'h01, 1'b0, 13'h0002), 1'b0);
		chk({operand_a, first_source_selector}, {32'h100, 5'h01});
		chk(operand_b, 32'h7);
		run({2'h1, 30'h3fffffff}, 1'b0);
		chk({kind == kind_call, is_delayed, next_is_delay_slot}, 3'h7);
		chk(transfer_target, 32'hffc);
		run({2'h0, 5'h00, 3'h2, 22'h000003}, 1'b0);
		chk({transfer_target, is_delayed}, {32'h100c, 1'b1});
		run({2'h0, 5'h03, 3'h4, 22'h3fffff}, 1'b0);
		chk({upper_result, keeps_cond_codes}, {32'hfffffc00, 1'b1});
		run(32'h0, 1'b0);
		chk({traps.illegal, kind == kind_illegal}, 2'h3);
		run(f3(2'h2, 6'h38, 5'h01, 1'b1, 13'h0008), 1'b0);
		chk({transfer_target, is_delayed}, {32'h108, 1'b1});
		run(f3(2'h2, 6'h3a, 5'h01, 1'b0, 13'h0002), 1'b0);
		chk({transfer_target, is_transfer, is_delayed}, {32'h107, 2'h2});
		run(f3(2'h2, 6'h20, 5'h01, 1'b0, 13'h0002), 1'b0);
		chk(traps.tag_overflow, 1'b1);
		run(f3(2'h2, 6'h22, 5'h01, 1'b0, 13'h0000), 1'b0);
		chk(traps.tag_overflow, 1'b0);
		run(f3(2'h2, 6'h25, 5'h01, 1'b1, 13'h0003), 1'b0);
		chk(keeps_cond_codes, 1'b1);
		run(f3(2'h2, 6'h34, 5'h01, 1'b1, 13'h0b42), 1'b0);
		chk({float_coproc_op, operand_b}, {9'h15a, 32'h7});
		chk({format_three_opcode, second_source_selector}, {6'h34, 5'h02});
		chk({major_format_field, kind == kind_arith}, 3'h5);
		#1 insn_valid = 1'b0;
		@(posedge core_clk);
		#2 chk({is_transfer, mem_req.valid}, 2'h0);
		chk(n_access, 10);
		test_done();
	end
endmodule // tb_risc_instruction_field_decoder
